// [rtl/css_pkg.sv]
// Purpose: Shared constants of the controller status flag block
// Assumes: Registers sit on a 32-bit classic Wishbone bus, byte addressed
// Notes: Bit positions index the 32-bit status word
package css_pkg;
  // Register byte offsets
  localparam logic [3:0] CSS_ADDR_STATUS = 4'h0;
  localparam logic [3:0] CSS_ADDR_CTRL = 4'h4;
  // Control register fields
  localparam int CSS_CTRL_RESET_BIT = 0;
  localparam int CSS_CTRL_SAVE_BIT = 1;
  // Status word bit positions
  localparam int CSS_BIT_WDT_BG = 0;
  localparam int CSS_BIT_WDT_RT = 1;
  localparam int CSS_BIT_STARTUP = 2;
  localparam int CSS_BIT_PROJECT = 3;
  localparam int CSS_BIT_SETTINGS = 4;
  localparam int CSS_BIT_HW_SWAP = 5;
  localparam int CSS_BIT_SYSFILE = 6;
  localparam int CSS_BIT_DEFAULT = 7;
  localparam int CSS_BIT_TIMING = 8;
  localparam int CSS_BIT_STOP = 9;
  localparam int CSS_BIT_BUFFER = 10;
  localparam int CSS_BIT_PROGRAM = 11;
  localparam int CSS_BIT_EXP_LO = 12;
  localparam int CSS_BIT_EXP_HI = 15;
  // Reset value of the status word and unmapped reads
  localparam logic [31:0] CSS_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] CSS_READ_NONE = 32'h0000_0000;
  // Cycles spent in start-up evaluation, lets pin synchronisers settle
  localparam int CSS_SETTLE_CYC = 3;
  // Block state
  typedef enum logic [0:0] {CSS_ST_INIT, CSS_ST_RUN} css_state_type;
endpackage

// [rtl/css_reg_if.sv]
// Purpose: Carries register accesses from the bus slave to the core
// Assumes: One access in flight at a time
// Notes: wr_pulse is one cycle, at the edge that completes the write
`timescale 1ns/100ps
`default_nettype none
interface css_reg_if;
  logic [3:0] addr;
  logic wr_pulse;
  logic [31:0] wr_data;
  logic [3:0] sel;
  logic [31:0] rd_data;
  modport bus (output addr, output wr_pulse, output wr_data, output sel,
    input rd_data);
  modport core (input addr, input wr_pulse, input wr_data, input sel,
    output rd_data);
endinterface
`default_nettype wire

// [rtl/css_wb_slave.sv]
// Purpose: Classic Wishbone slave for the status flag registers
// Assumes: Master holds the request until it samples ack
// Notes: Ack comes one cycle after the request and lasts one cycle
`timescale 1ns/100ps
`default_nettype none
module css_wb_slave (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Strobe
  input wire logic we_i, // Write enable
  input wire logic [3:0] adr_i, // Byte address
  input wire logic [3:0] sel_i, // Byte lanes
  input wire logic [31:0] dat_i, // Write data
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Acknowledge
  css_reg_if.bus regs // Register side
);
  logic ack_q;
  logic [31:0] dat_q;

  // Request passes straight to the core for decode
  assign regs.addr = adr_i;
  assign regs.wr_data = dat_i;
  assign regs.sel = sel_i;
  // Write takes effect at the edge where the master samples ack
  assign regs.wr_pulse = cyc_i & stb_i & we_i & ack_q;
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // Ack for one cycle, dropped right after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i & stb_i & ~ack_q;
    end
  end

  // Read data captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (cyc_i & stb_i & ~ack_q & ~we_i) begin
      dat_q <= regs.rd_data;
    end
  end
endmodule
`default_nettype wire

// [rtl/css_status_top.sv]
// Purpose: Controller status word with error and condition flags
// Assumes: Loader and firmware inputs are on clk_i; pins are asynchronous
// Notes: Status is read-only; control register issues reset and save
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module css_status_top #(
  parameter int SIZE_W = 32, // Width of size figures
  parameter logic [SIZE_W-1:0] FLASH_CAP = 32'h0100_0000, // Flash bytes
  parameter logic [SIZE_W-1:0] RAM_CAP = 32'h0040_0000, // RAM bytes
  parameter logic [SIZE_W-1:0] BUF_DEFAULT = 32'h0001_0000 // Default buffer
) (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic rst_i, // Power-on reset, synchronous, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [3:0] adr_i, // Wishbone byte address
  input wire logic [3:0] sel_i, // Wishbone byte lanes
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic abort_all_i, // Abort-all pin, asynchronous
  input wire logic phase_clk_ok_i, // Phase clock seen, asynchronous
  input wire logic servo_clk_ok_i, // Servo clock seen, asynchronous
  input wire logic usb_folder_i, // Restore folder present, asynchronous
  input wire logic wdt_rt_fault_i, // Realtime watchdog fault pulse
  input wire logic wdt_bg_fault_i, // Background watchdog fault pulse
  input wire logic sys_file_fault_i, // System file fault at load
  input wire logic settings_fault_i, // Saved settings fault at load
  input wire logic project_fault_i, // Project file fault at load
  input wire logic factory_state_i, // Configuration is factory default
  input wire logic cfg_changed_i, // Configuration changed pulse
  input wire logic [SIZE_W-1:0] prog_size_i, // User program size
  input wire logic [SIZE_W-1:0] cfg_buf_size_i, // Configured buffer size
  output logic [SIZE_W-1:0] buf_size_o, // Buffer size in use
  output logic save_store_o, // Save accepted, store pulse
  output logic factory_restore_o, // Factory restore pulse
  output logic [31:0] status_o // Status word
);
  import css_pkg::*;

  css_reg_if regs ();
  css_state_type state_q;
  logic [1:0] cnt_q;
  logic por_q;
  logic [3:0] s1_q, s2_q;
  logic [31:0] flags_q, flags_d, status_w;
  logic [SIZE_W-1:0] buf_q;
  logic store_q, restore_q;
  logic wr_ctrl, reset_cmd, save_cmd, init_eval, save_go, too_big;

  // Register bus slave
  css_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .regs(regs)
  );

  // Byte address decode shared by reads and writes
  function automatic logic is_addr(input logic [3:0] a, input logic [3:0] o);
    is_addr = (a[3:2] == o[3:2]);
  endfunction

  // Two-flop synchronisers for the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end else begin
      s1_q <= {usb_folder_i, servo_clk_ok_i, phase_clk_ok_i, abort_all_i};
      s2_q <= s1_q;
    end
  end

  // Control writes; status word writes fall through unused
  assign wr_ctrl = regs.wr_pulse & is_addr(regs.addr, CSS_ADDR_CTRL)
    & regs.sel[0];
  assign reset_cmd = wr_ctrl & regs.wr_data[CSS_CTRL_RESET_BIT];
  assign save_cmd = wr_ctrl & regs.wr_data[CSS_CTRL_SAVE_BIT]
    & ~regs.wr_data[CSS_CTRL_RESET_BIT];
  assign init_eval = (state_q == CSS_ST_INIT)
    && (cnt_q == 2'(CSS_SETTLE_CYC - 1));
  assign save_go = (state_q == CSS_ST_RUN) && save_cmd;
  assign too_big = prog_size_i > FLASH_CAP;

  // Read decode
  always_comb begin
    if (is_addr(regs.addr, CSS_ADDR_STATUS)) begin
      regs.rd_data = status_w;
    end else begin
      regs.rd_data = CSS_READ_NONE;
    end
  end

  // Start-up evaluation after power-on or reset command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= CSS_ST_INIT;
      cnt_q <= 2'h0;
      por_q <= 1'b1;
    end else begin
      case (state_q)
        CSS_ST_INIT: begin
          cnt_q <= cnt_q + 2'h1;
          if (init_eval) begin
            state_q <= CSS_ST_RUN;
            por_q <= 1'b0;
          end
        end
        default: begin
          cnt_q <= 2'h0;
          if (reset_cmd) begin
            state_q <= CSS_ST_INIT;
          end
        end
      endcase
    end
  end

  // Flag next value; a set in the clearing cycle wins
  always_comb begin
    flags_d = reset_cmd ? CSS_STATUS_RESET : flags_q;
    if (wdt_rt_fault_i) begin
      flags_d[CSS_BIT_WDT_RT] = 1'b1;
    end
    if (wdt_bg_fault_i) begin
      flags_d[CSS_BIT_WDT_BG] = 1'b1;
    end
    if (s2_q[0]) begin
      flags_d[CSS_BIT_STOP] = 1'b1;
    end
    if (cfg_changed_i) begin
      flags_d[CSS_BIT_DEFAULT] = 1'b1;
    end
    if (save_go) begin
      flags_d[CSS_BIT_PROGRAM] = too_big;
    end
    if (init_eval) begin
      flags_d[CSS_BIT_TIMING] = ~(s2_q[1] & s2_q[2]);
      flags_d[CSS_BIT_SYSFILE] = sys_file_fault_i;
      flags_d[CSS_BIT_SETTINGS] = settings_fault_i;
      flags_d[CSS_BIT_PROJECT] = project_fault_i;
      flags_d[CSS_BIT_DEFAULT] = factory_state_i | (por_q & s2_q[3])
        | flags_d[CSS_BIT_DEFAULT];
      flags_d[CSS_BIT_BUFFER] = cfg_buf_size_i > RAM_CAP;
    end
  end

  // Flags live in flip-flops only and clear at power-on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= CSS_STATUS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Status word assembly with fixed zero fields
  always_comb begin
    status_w = CSS_STATUS_RESET;
    status_w[CSS_BIT_PROGRAM:CSS_BIT_PROJECT] =
      flags_q[CSS_BIT_PROGRAM:CSS_BIT_PROJECT];
    status_w[CSS_BIT_HW_SWAP] = 1'b0;
    status_w[CSS_BIT_STARTUP] = flags_q[CSS_BIT_SYSFILE]
      | flags_q[CSS_BIT_SETTINGS] | flags_q[CSS_BIT_PROJECT];
    status_w[CSS_BIT_WDT_RT] = flags_q[CSS_BIT_WDT_RT];
    status_w[CSS_BIT_WDT_BG] = flags_q[CSS_BIT_WDT_BG];
  end
  assign status_o = status_w;

  // Buffer size in use, default substituted when too large
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_q <= BUF_DEFAULT;
    end else if (init_eval) begin
      buf_q <= (cfg_buf_size_i > RAM_CAP) ? BUF_DEFAULT
        : cfg_buf_size_i;
    end
  end
  assign buf_size_o = buf_q;

  // Save store and factory restore pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      store_q <= 1'b0;
      restore_q <= 1'b0;
    end else begin
      store_q <= save_go & ~too_big;
      restore_q <= init_eval & por_q & s2_q[3];
    end
  end
  assign save_store_o = store_q;
  assign factory_restore_o = restore_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_upper_zero;
    status_o[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("status upper half not zero");

  property p_fixed_zero;
    status_o[CSS_BIT_EXP_HI:CSS_BIT_EXP_LO] == 4'h0
      && !status_o[CSS_BIT_HW_SWAP];
  endproperty
  a_fixed_zero: assert property (p_fixed_zero)
    else $error("disabled status bits not zero");

  property p_summary;
    status_o[CSS_BIT_STARTUP] == |status_o[CSS_BIT_SYSFILE:CSS_BIT_PROJECT];
  endproperty
  a_summary: assert property (p_summary)
    else $error("startup fault summary wrong");

  property p_watchdog;
    wdt_rt_fault_i |=> status_o[CSS_BIT_WDT_RT] [*2];
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("realtime watchdog flag not held");

  property p_no_clock;
    init_eval && !s2_q[1] |=> status_o[CSS_BIT_TIMING];
  endproperty
  a_no_clock: assert property (p_no_clock)
    else $error("missing phase clock not flagged");

  property p_volatile;
    disable iff (1'b0) rst_i |=> status_o == CSS_STATUS_RESET;
  endproperty
  a_volatile: assert property (p_volatile)
    else $error("status survived reset");

  property p_too_big;
    save_go && too_big |=> status_o[CSS_BIT_PROGRAM] && !save_store_o;
  endproperty
  a_too_big: assert property (p_too_big)
    else $error("oversized save not refused");

  property p_fits;
    save_go && !too_big |=> !status_o[CSS_BIT_PROGRAM] && save_store_o;
  endproperty
  a_fits: assert property (p_fits)
    else $error("fitting save not stored");

  property p_buffer;
    init_eval && cfg_buf_size_i > RAM_CAP
      |=> status_o[CSS_BIT_BUFFER] && buf_size_o == BUF_DEFAULT;
  endproperty
  a_buffer: assert property (p_buffer)
    else $error("buffer oversize not handled");

  property p_sticky;
    status_o[CSS_BIT_STOP] && !reset_cmd |=> status_o[CSS_BIT_STOP];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("stop flag lost without reset");

  property p_abort;
    s2_q[0] |=> status_o[CSS_BIT_STOP];
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort not recorded");

  property p_restore;
    init_eval && por_q && s2_q[3]
      |=> factory_restore_o && status_o[CSS_BIT_DEFAULT];
  endproperty
  a_restore: assert property (p_restore)
    else $error("factory restore missed");

  property p_changed;
    cfg_changed_i |=> status_o[CSS_BIT_DEFAULT];
  endproperty
  a_changed: assert property (p_changed)
    else $error("config change not flagged");

  property p_read_only;
    regs.wr_pulse && is_addr(regs.addr, CSS_ADDR_STATUS)
      && flags_d == flags_q |=> $stable(status_o);
  endproperty
  a_read_only: assert property (p_read_only)
    else $error("status changed by host write");

  c_save_refused: cover property (save_go && too_big);
  c_restore: cover property (factory_restore_o);
  c_reset_cmd: cover property (reset_cmd ##[1:4] state_q == CSS_ST_RUN);
endmodule
`default_nettype wire

// [verif/css_usb_model.sv]
// Purpose: Removable storage holding the restore folder
// Assumes: Bench asks for mounting; storage follows only when unpowered
// Notes: Counts factory restore pulses the block gives
`timescale 1ns/100ps
`default_nettype none
module css_usb_model (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Power-on reset, high while unpowered
  input wire logic mount_i, // Operator wants storage attached
  input wire logic restore_i, // Factory restore pulse from block
  output var logic folder_o, // Restore folder present
  output var int restores_o // Number of restores seen
);
  // Storage changes only while the device is unpowered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      folder_o <= mount_i;
    end
  end
  // Count restores, kept across resets
  int count_q = 0;
  always_ff @(posedge clk_i) begin
    if (restore_i === 1'b1) begin
      count_q <= count_q + 1;
    end
  end
  assign restores_o = count_q;
endmodule
`default_nettype wire

// [verif/controller_status_flags_tb.sv]
// Purpose: Self-checking bench of the status flag block
// Assumes: Bus answers one cycle after a request
// Notes: Fixed waits follow the start-up and abort sync counts
`timescale 1ns/100ps
`default_nettype none
module controller_status_flags_tb;
  import css_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mount = 1;
  logic [3:0] adr = 0;
  logic [31:0] dat = 0, dat_o, status_o, buf_o, psize = 0;
  logic [31:0] bsize = 32'h0080_0000;
  logic ack, abrt = 0, ph = 0, sv = 1, wrt = 0, wbg = 0, sysf = 0;
  logic setf = 0, proj = 1, fst = 0, chg = 0, store, rest, fold;
  int err_count = 0, n_tests = 0, stores = 0, restores;
  always #5 clk_i = ~clk_i;
  css_status_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack), .abort_all_i(abrt), .phase_clk_ok_i(ph),
    .servo_clk_ok_i(sv), .usb_folder_i(fold), .wdt_rt_fault_i(wrt),
    .wdt_bg_fault_i(wbg), .sys_file_fault_i(sysf),
    .settings_fault_i(setf), .project_fault_i(proj),
    .factory_state_i(fst), .cfg_changed_i(chg), .prog_size_i(psize),
    .cfg_buf_size_i(bsize), .buf_size_o(buf_o), .save_store_o(store),
    .factory_restore_o(rest), .status_o(status_o));
  css_usb_model usb (.clk_i(clk_i), .rst_i(rst_i), .mount_i(mount),
    .restore_i(rest), .folder_o(fold), .restores_o(restores));
  // Count accepted saves
  always @(posedge clk_i) begin
    if (store === 1'b1) begin
      stores++;
    end
  end
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic bus cycle, waits for ack under a bound
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_i);
    if (n >= 50) begin
      chk({31'h0, ack}, 32'h1);
      finish_test();
    end
  endtask
  // Read status over the bus and at the pin
  task automatic st(input logic [31:0] e);
    logic [31:0] q;
    wb(0, CSS_ADDR_STATUS, 32'h0, q);
    chk(q, e);
    chk(status_o, e);
  endtask
  // Write the control register, then let evaluation finish
  task automatic ctl(input logic [31:0] v);
    logic [31:0] q;
    wb(1, CSS_ADDR_CTRL, v, q);
    repeat (6) @(posedge clk_i);
  endtask
  // Power-on with folder, oversized buffer, clock lost, project fault
  task automatic t_init();
    logic [31:0] q;
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    repeat (6) @(posedge clk_i);
    st(32'h0000_058C);
    chk(status_o & 32'hFFFF_F020, 32'h0);
    chk(buf_o, 32'h0001_0000);
    chk(restores, 1);
    wb(1, CSS_ADDR_STATUS, 32'hFFFF_FFFF, q);
    st(32'h0000_058C);
    wb(0, 4'h8, 32'h0, q);
    chk(q, 32'h0);
    $display("test init done");
  endtask
  // Oversized save refused, fitting save stored
  task automatic t_save();
    psize <= 32'h0200_0000;
    ctl(32'h2);
    st(32'h0000_0D8C);
    chk(stores, 0);
    psize <= 32'h0000_0100;
    ctl(32'h2);
    st(32'h0000_058C);
    chk(stores, 1);
    $display("test save done");
  endtask
  // Abort and watchdog flags stay after their causes end
  task automatic t_sticky();
    abrt <= 1;
    repeat (2) @(posedge clk_i);
    abrt <= 0;
    wrt <= 1;
    wbg <= 1;
    @(posedge clk_i);
    wrt <= 0;
    wbg <= 0;
    repeat (6) @(posedge clk_i);
    st(32'h0000_078F);
    st(32'h0000_078F);
    $display("test sticky done");
  endtask
  // Reset command clears flags, no restore; change sets default
  task automatic t_rcmd();
    ph <= 1;
    proj <= 0;
    bsize <= 32'h0000_1000;
    ctl(32'h3);
    st(32'h0);
    chk(buf_o, 32'h0000_1000);
    chk(restores, 1);
    chk(stores, 1);
    chg <= 1;
    @(posedge clk_i);
    chg <= 0;
    repeat (2) @(posedge clk_i);
    st(32'h0000_0080);
    $display("test reset command done");
  endtask
  // Power cycle without storage; load faults and factory state
  task automatic t_power();
    rst_i <= 1;
    mount <= 0;
    fst <= 1;
    sysf <= 1;
    setf <= 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    repeat (6) @(posedge clk_i);
    st(32'h0000_00D4);
    st(32'h0000_00D4);
    chk(restores, 1);
    $display("test power cycle done");
  endtask
  // Main sequence
  initial begin
    t_init();
    t_save();
    t_sticky();
    t_rcmd();
    t_power();
    finish_test();
  end
endmodule
`default_nettype wire
